// ===== hw/rfid_protocol_config.sv
/*
 * protocol configuration bank of the reader front end: protocol_select,
 * tx_pulse_length and no_response_wait behind a parallel host port, the
 * modulation pulse timer and the no-response slot timer.
 * assumes: host port pins and the enable pin are asynchronous to clk_sys;
 * the framing engine signals run on clk_sys.
 */
// Notes on behaviour
// R1 - protocol select loads 0x02 on reset/disable
// R2 - bit 7 set: responses carry no CRC
// R3 - bit 6 picks raw mode 0 or 1
// R4 - host keeps bit 5 zero, reader mode
// R5 - single subcarrier: 6.62 or 26.48 kbps
// R6 - double subcarrier: 6.67 or 26.69 kbps
// R7 - bit 0 picks 1-of-4 or 1-of-256 coding
// R8 - pulse length zero uses protocol pulse
// R9 - nonzero pulse length N gives N*73.7 ns
// R10 - pulse length cleared on reset/disable/select write
// R11 - no tag answer in slot raises interrupt
// R12 - no-response time is N*37.76 us after EOF
// R13 - no-response register presets to 0x0e
// R14 - select write presets 755 or 1812 us
// R15 - host sets raw type before raw enable
// R16 - host writes only protocol codes 0..7
// R17 - time steps counted in whole carrier cycles
`timescale 1ns/1ps
`include "rfid_cfg_regs.svh"

module rfid_protocol_config (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_en,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_wr,
    input wire logic host_rd,
    output logic [7:0] host_rdata_ff,
    output logic host_rvalid_ff,
    input wire logic tx_pulse_req,
    input wire logic tx_eof_done,
    input wire logic anticoll_slot,
    input wire logic tag_resp_start,
    output logic [7:0] protocol_select_ff,
    output logic rx_crc_check_ff,
    output logic raw_mode1_ff,
    output logic reader_mode_ff,
    output rfid_cfg_pkg::bit_rate_t bit_rate_ff,
    output logic coding_256_ff,
    output logic mod_pulse_ff,
    output logic no_resp_irq_ff,
    output logic no_resp_flag_ff
);
    import rfid_cfg_pkg::*;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [15:0] pins_meta_ff;
    logic [15:0] pins_sync_ff;
    logic wr_seen_ff;
    logic rd_seen_ff;
    logic [4:0] addr_s;
    logic [7:0] wdata_s;
    logic wr_s;
    logic rd_s;
    logic en_s;
    logic wr_pulse;
    logic rd_pulse;
    logic hold_defaults;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins_meta_ff <= 16'h0000;
            pins_sync_ff <= 16'h0000;
        end else begin
            pins_meta_ff <= {chip_en, host_rd, host_wr, host_wdata, host_addr};
            pins_sync_ff <= pins_meta_ff;
        end
    end

    assign addr_s = pins_sync_ff[4:0];
    assign wdata_s = pins_sync_ff[12:5];
    assign wr_s = pins_sync_ff[13];
    assign rd_s = pins_sync_ff[14];
    assign en_s = pins_sync_ff[15];
    assign hold_defaults = rst || !en_s;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_seen_ff <= 1'b0;
            rd_seen_ff <= 1'b0;
        end else begin
            wr_seen_ff <= wr_s;
            rd_seen_ff <= rd_s;
        end
    end

    assign wr_pulse = wr_s && !wr_seen_ff && en_s;
    assign rd_pulse = rd_s && !rd_seen_ff;

    // ------------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------------
    logic [7:0] tx_pulse_length_ff;
    logic [7:0] no_response_wait_ff;
    logic [7:0] nxt_protocol_select;
    logic proto_wr;
    logic [7:0] noresp_preset;

    assign proto_wr = wr_pulse && (addr_s == `ADDR_PROTOCOL_SELECT);
    assign nxt_protocol_select = proto_wr ? wdata_s : protocol_select_ff;
    // rate decides the no-response preset [R14]
    assign noresp_preset = wdata_s[`BIT_HIGH_RATE] ? 8'(`NORESP_PRESET_HIGH)
                                                   : 8'(`NORESP_PRESET_LOW);

    always_ff @(posedge clk_sys) begin
        if (hold_defaults) begin
            protocol_select_ff <= `PROTOCOL_SELECT_RST; // [R1]
        end else begin
            protocol_select_ff <= nxt_protocol_select;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_defaults) begin
            tx_pulse_length_ff <= `TX_PULSE_LENGTH_RST; // [R10]
        end else if (proto_wr) begin
            tx_pulse_length_ff <= `TX_PULSE_LENGTH_RST; // [R10]
        end else if (wr_pulse && addr_s == `ADDR_TX_PULSE_LENGTH) begin
            tx_pulse_length_ff <= wdata_s;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_defaults) begin
            no_response_wait_ff <= `NO_RESPONSE_WAIT_RST; // [R13]
        end else if (proto_wr) begin
            no_response_wait_ff <= noresp_preset; // [R14]
        end else if (wr_pulse && addr_s == `ADDR_NO_RESPONSE_WAIT) begin
            no_response_wait_ff <= wdata_s;
        end
    end

    // ------------------------------------------------------------------------
    // decoded protocol fields
    // ------------------------------------------------------------------------
    logic [7:0] dec_src;

    assign dec_src = hold_defaults ? `PROTOCOL_SELECT_RST : nxt_protocol_select;

    always_ff @(posedge clk_sys) begin
        rx_crc_check_ff <= !dec_src[`BIT_NO_RX_CRC]; // [R2]
        raw_mode1_ff <= dec_src[`BIT_RAW_TYPE]; // [R3]
        reader_mode_ff <= !dec_src[`BIT_READER_MODE];
        coding_256_ff <= dec_src[`BIT_CODING_256]; // [R7]
    end

    always_ff @(posedge clk_sys) begin
        case ({dec_src[`BIT_DOUBLE_SUBCARRIER], dec_src[`BIT_HIGH_RATE]})
            2'b00: begin
                bit_rate_ff <= RATE_6K62; // [R5]
            end
            2'b01: begin
                bit_rate_ff <= RATE_26K48; // [R5]
            end
            2'b10: begin
                bit_rate_ff <= RATE_6K67; // [R6]
            end
            default: begin
                bit_rate_ff <= RATE_26K69; // [R6]
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // host reads
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_rdata_ff <= 8'h00;
            host_rvalid_ff <= 1'b0;
        end else begin
            host_rvalid_ff <= rd_pulse;
            if (rd_pulse) begin
                case (addr_s)
                    `ADDR_PROTOCOL_SELECT: begin
                        host_rdata_ff <= protocol_select_ff;
                    end
                    `ADDR_TX_PULSE_LENGTH: begin
                        host_rdata_ff <= tx_pulse_length_ff;
                    end
                    `ADDR_NO_RESPONSE_WAIT: begin
                        host_rdata_ff <= no_response_wait_ff;
                    end
                    default: begin
                        host_rdata_ff <= 8'h00;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // carrier-cycle time base
    // ------------------------------------------------------------------------
    logic tick;

    carrier_tick u_tick ( // [R17]
        .clk_sys(clk_sys),
        .rst(rst),
        .tick_ff(tick)
    );

    // ------------------------------------------------------------------------
    // modulation pulse timer
    // ------------------------------------------------------------------------
    logic [7:0] pulse_len;
    logic pulse_busy;

    // zero override falls back to the protocol pulse [R8]
    assign pulse_len = (tx_pulse_length_ff == 8'h00) ? 8'(`PULSE_DEFAULT_TICKS)
                                                      : tx_pulse_length_ff; // [R9]

    step_timer #(
        .STEP_TICKS(`PULSE_STEP_TICKS)
    ) u_pulse (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .start(tx_pulse_req && !pulse_busy),
        .abort(hold_defaults),
        .len(pulse_len),
        .busy_ff(pulse_busy),
        .done_ff()
    );

    always_ff @(posedge clk_sys) begin
        if (hold_defaults) begin
            mod_pulse_ff <= 1'b0;
        end else begin
            mod_pulse_ff <= pulse_busy; // [R9]
        end
    end

    // ------------------------------------------------------------------------
    // no-response slot timer
    // ------------------------------------------------------------------------
    slot_state_t slot_ff;
    logic slot_start;
    logic slot_busy;
    logic slot_done;

    assign slot_start = tx_eof_done && anticoll_slot && (no_response_wait_ff != 8'h00);

    step_timer #(
        .STEP_TICKS(`NORESP_STEP_TICKS)
    ) u_slot (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .start(slot_start), // [R12]
        .abort(hold_defaults || tag_resp_start),
        .len(no_response_wait_ff),
        .busy_ff(slot_busy),
        .done_ff(slot_done)
    );

    always_ff @(posedge clk_sys) begin
        if (hold_defaults) begin
            slot_ff <= SLOT_IDLE;
        end else begin
            case (slot_ff)
                SLOT_IDLE: begin
                    if (slot_start) begin
                        slot_ff <= SLOT_WAIT;
                    end
                end
                SLOT_WAIT: begin
                    if (tag_resp_start) begin
                        slot_ff <= SLOT_IDLE;
                    end else if (slot_done) begin
                        slot_ff <= SLOT_HIT; // [R11]
                    end else if (!slot_busy) begin
                        slot_ff <= SLOT_IDLE;
                    end
                end
                SLOT_HIT: begin
                    slot_ff <= slot_start ? SLOT_WAIT : SLOT_IDLE;
                end
                default: begin
                    slot_ff <= SLOT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (hold_defaults) begin
            no_resp_irq_ff <= 1'b0;
            no_resp_flag_ff <= 1'b0;
        end else begin
            no_resp_irq_ff <= (slot_ff == SLOT_WAIT) && slot_done && !tag_resp_start; // [R11]
            if ((slot_ff == SLOT_WAIT) && slot_done && !tag_resp_start) begin
                no_resp_flag_ff <= 1'b1; // [R11]
            end else if (slot_start) begin
                no_resp_flag_ff <= 1'b0;
            end
        end
    end

endmodule // rfid_protocol_config

// ===== hw/rfid_cfg_regs.svh
/*
 * register offsets, field positions, reset values and timing constants of the
 * protocol configuration bank.
 * assumes: included by bare name from the top module and the carrier tick generator.
 */
`ifndef RFID_CFG_REGS_SVH
`define RFID_CFG_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets on the host port
// ----------------------------------------------------------------------------
`define ADDR_W 5
`define ADDR_PROTOCOL_SELECT 5'h01
`define ADDR_TX_PULSE_LENGTH 5'h06
`define ADDR_NO_RESPONSE_WAIT 5'h07

// ----------------------------------------------------------------------------
// reset and preset values
// ----------------------------------------------------------------------------
`define PROTOCOL_SELECT_RST 8'h02
`define TX_PULSE_LENGTH_RST 8'h00
`define NO_RESPONSE_WAIT_RST 8'h0e

// ----------------------------------------------------------------------------
// protocol_select field positions
// ----------------------------------------------------------------------------
`define BIT_NO_RX_CRC 7
`define BIT_RAW_TYPE 6
`define BIT_READER_MODE 5
`define BIT_DOUBLE_SUBCARRIER 2
`define BIT_HIGH_RATE 1
`define BIT_CODING_256 0

// ----------------------------------------------------------------------------
// clocks and time steps
// ----------------------------------------------------------------------------
`define CLK_KHZ 40000
`define CARRIER_KHZ 13560
`define PHASE_INC (`CARRIER_KHZ / 10)
`define PHASE_MOD (`CLK_KHZ / 10)
`define PULSE_STEP_PS 73700
`define PULSE_STEP_TICKS ((`PULSE_STEP_PS * `CARRIER_KHZ + 500000000) / 1000000000)
`define PULSE_DEFAULT_NS 9440
`define PULSE_DEFAULT_TICKS ((`PULSE_DEFAULT_NS * `CARRIER_KHZ + 500000) / 1000000)
`define NORESP_STEP_NS 37760
`define NORESP_STEP_TICKS ((`NORESP_STEP_NS * `CARRIER_KHZ + 500000) / 1000000)
`define NORESP_HIGH_RATE_NS 755000
`define NORESP_LOW_RATE_NS 1812000
`define NORESP_PRESET_HIGH ((`NORESP_HIGH_RATE_NS + `NORESP_STEP_NS / 2) / `NORESP_STEP_NS)
`define NORESP_PRESET_LOW ((`NORESP_LOW_RATE_NS + `NORESP_STEP_NS / 2) / `NORESP_STEP_NS)

`endif

// ===== hw/rfid_cfg_pkg.sv
/*
 * types of the protocol configuration bank.
 * assumes: rfid_cfg_regs.svh holds the numeric constants.
 */
package rfid_cfg_pkg;

    // ------------------------------------------------------------------------
    // decoded bit rate and timer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_6K62,
        RATE_26K48,
        RATE_6K67,
        RATE_26K69
    } bit_rate_t;

    typedef enum logic [1:0] {
        SLOT_IDLE,
        SLOT_WAIT,
        SLOT_HIT
    } slot_state_t;

endpackage

// ===== hw/carrier_tick.sv
/*
 * carrier tick generator: one-cycle pulse at the mean rate of the 13.56 MHz
 * oscillator, made by a phase accumulator on the system clock.
 * assumes: clk_sys at 40 MHz, synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "rfid_cfg_regs.svh"

module carrier_tick (
    input wire logic clk_sys,
    input wire logic rst,
    output logic tick_ff
);
    logic [11:0] phase_ff;
    logic [12:0] nxt_sum;

    // ------------------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------------------
    assign nxt_sum = {1'b0, phase_ff} + 13'(`PHASE_INC);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_ff <= 12'h000;
            tick_ff <= 1'b0;
        end else if (nxt_sum >= 13'(`PHASE_MOD)) begin
            phase_ff <= 12'(nxt_sum - 13'(`PHASE_MOD));
            tick_ff <= 1'b1;
        end else begin
            phase_ff <= nxt_sum[11:0];
            tick_ff <= 1'b0;
        end
    end
endmodule // carrier_tick

// ===== hw/step_timer.sv
/*
 * step timer: after start, stays busy for len steps of STEP_TICKS carrier
 * ticks each, then gives a one-cycle done. len zero never goes busy.
 * assumes: tick is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ps

module step_timer #(
    parameter int STEP_TICKS = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] len,
    output logic busy_ff,
    output logic done_ff
);
    logic [9:0] sub_ff;
    logic [7:0] steps_ff;

    // ------------------------------------------------------------------------
    // step and sub-step counters
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || abort) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            sub_ff <= 10'h000;
            steps_ff <= 8'h00;
        end else if (start) begin
            busy_ff <= (len != 8'h00);
            done_ff <= 1'b0;
            sub_ff <= 10'h000;
            steps_ff <= len;
        end else begin
            done_ff <= 1'b0;
            if (busy_ff && tick) begin
                if (sub_ff == 10'(STEP_TICKS - 1)) begin
                    sub_ff <= 10'h000;
                    if (steps_ff == 8'h01) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end
                    steps_ff <= steps_ff - 8'h01;
                end else begin
                    sub_ff <= sub_ff + 10'h001;
                end
            end
        end
    end
endmodule // step_timer

// ===== test/rfid_cfg_monitor.sv
/* checker of the protocol configuration bank, bound to its top module.
   assumes: clk_sys domain only, rst synchronous active high. */
`timescale 1ns/1ps
module rfid_cfg_monitor
    import rfid_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_en,
    input wire logic tx_pulse_req,
    input wire logic tag_resp_start,
    input wire logic [7:0] protocol_select_ff,
    input wire logic rx_crc_check_ff,
    input wire logic raw_mode1_ff,
    input wire bit_rate_t bit_rate_ff,
    input wire logic coding_256_ff,
    input wire logic mod_pulse_ff,
    input wire logic no_resp_irq_ff,
    input wire logic no_resp_flag_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    sequence quiet_irq;
        !no_resp_irq_ff [*6];
    endsequence
    reset_preset_a: assert property ($fell(rst) |-> protocol_select_ff == 8'h02)
        else $error("select not preset after reset");
    disable_preset_a: assert property (!chip_en [*5] |-> protocol_select_ff == 8'h02)
        else $error("select not preset while disabled");
    crc_decode_a: assert property (rx_crc_check_ff == !protocol_select_ff[7])
        else $error("crc expectation wrong");
    raw_decode_a: assert property (raw_mode1_ff == protocol_select_ff[6])
        else $error("raw type wrong");
    rate_decode_a: assert property (bit_rate_ff == protocol_select_ff[2:1])
        else $error("bit rate wrong");
    coding_decode_a: assert property (coding_256_ff == protocol_select_ff[0])
        else $error("coding wrong");
    pulse_launch_a: assert property ($rose(mod_pulse_ff) |-> $past(tx_pulse_req, 2))
        else $error("pulse without request");
    irq_pulse_a: assert property (no_resp_irq_ff |=> !no_resp_irq_ff)
        else $error("irq longer than one cycle");
    irq_flag_a: assert property (no_resp_irq_ff |-> no_resp_flag_ff)
        else $error("irq without flag");
    cancel_quiet_a: assert property (tag_resp_start |-> ##2 quiet_irq)
        else $error("irq after tag response");
endmodule // rfid_cfg_monitor
bind rfid_protocol_config rfid_cfg_monitor u_rfid_cfg_monitor (.clk_sys, .rst, .chip_en,
    .tx_pulse_req, .tag_resp_start, .protocol_select_ff, .rx_crc_check_ff, .raw_mode1_ff,
    .bit_rate_ff, .coding_256_ff, .mod_pulse_ff, .no_resp_irq_ff, .no_resp_flag_ff);

// ===== test/host_model.sv
/* host controller model: parallel register strobes and the enable pin.
   assumes: block synchronises the pins, two cycles deep. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    output logic chip_en,
    output logic [4:0] host_addr,
    output logic [7:0] host_wdata,
    output logic host_wr,
    output logic host_rd
);
    initial begin
        chip_en = 1'b1;
        host_addr = 5'h1f;
        host_wdata = 8'h5a;
        host_wr = 1'b0;
        host_rd = 1'b0;
    end
    // lines first, strobe three cycles high, three low, then lines scrambled
    task automatic access(input logic [4:0] a, input logic [7:0] d, input logic is_wr);
        logic [7:0] v;
        v = d;
        if (a == 5'h01 && is_wr) begin
            v = d & 8'hc7; // reader mode, codes 0..7 only
        end
        @(posedge clk_sys);
        host_addr <= a;
        host_wdata <= v; // raw type set before any raw enable
        repeat (2) @(posedge clk_sys);
        host_wr <= is_wr;
        host_rd <= !is_wr;
        repeat (3) @(posedge clk_sys);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        repeat (3) @(posedge clk_sys);
        host_addr <= ~a;
        host_wdata <= ~v;
    endtask
    task automatic set_en(input logic e);
        @(posedge clk_sys);
        chip_en <= e;
    endtask
endmodule // host_model

// ===== test/tb_rfid_protocol_config.sv
/* self-checking bench of the protocol configuration bank.
   assumes: 40 MHz clk_sys, carrier ticks about 2.95 clocks apart. */
`timescale 1ns/1ps
module tb_rfid_protocol_config;
    import rfid_cfg_pkg::*;
    logic clk_sys, rst, chip_en, host_wr, host_rd, host_rvalid_ff;
    logic tx_pulse_req, tx_eof_done, anticoll_slot, tag_resp_start;
    logic rx_crc_check_ff, raw_mode1_ff, reader_mode_ff, coding_256_ff;
    logic mod_pulse_ff, no_resp_irq_ff, no_resp_flag_ff;
    logic [4:0] host_addr;
    logic [7:0] host_wdata, host_rdata_ff, protocol_select_ff, v;
    logic [7:0] exp_q[$];
    logic [7:0] plen[4] = '{8'h01, 8'h00, 8'hff, 8'h00};
    bit_rate_t bit_rate_ff;
    int err_total, total_checks, seed, i;
    wire logic [7:0] dec_out = {2'h0, rx_crc_check_ff, raw_mode1_ff, reader_mode_ff,
        bit_rate_ff, coding_256_ff};
    rfid_protocol_config u_rfid_protocol_config (.clk_sys, .rst, .chip_en, .host_addr,
        .host_wdata, .host_wr, .host_rd, .host_rdata_ff, .host_rvalid_ff, .tx_pulse_req,
        .tx_eof_done, .anticoll_slot, .tag_resp_start, .protocol_select_ff, .rx_crc_check_ff,
        .raw_mode1_ff, .reader_mode_ff, .bit_rate_ff, .coding_256_ff, .mod_pulse_ff,
        .no_resp_irq_ff, .no_resp_flag_ff);
    host_model u_host_model (.clk_sys, .chip_en, .host_addr, .host_wdata, .host_wr, .host_rd);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_near(input int got, input int exp, input int tol);
        total_checks++;
        if (got > exp + tol || got < exp - tol) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] dec(input logic [7:0] s);
        return {2'h0, ~s[7], s[6], ~s[5], s[2], s[1], s[0]};
    endfunction
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        u_host_model.access(a, d, 1'b1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host_model.access(a, 8'h00, 1'b0);
    endtask
    task automatic pulse(input int exp_w);
        int w;
        int n;
        w = 0;
        n = 0;
        tx_pulse_req <= 1'b1;
        @(posedge clk_sys);
        tx_pulse_req <= 1'b0;
        while (mod_pulse_ff !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
        while (mod_pulse_ff === 1'b1 && w < 2000) begin
            @(posedge clk_sys);
            w++;
        end
        cmp_near(w, exp_w, 4);
    endtask
    task automatic slot(input logic cancel, input int exp_c, input logic exp_f);
        int c;
        c = 0;
        tx_eof_done <= 1'b1;
        @(posedge clk_sys);
        tx_eof_done <= 1'b0;
        while (no_resp_irq_ff !== 1'b1 && c < 5000) begin
            @(posedge clk_sys);
            c++;
            tag_resp_start <= cancel && c == 500;
        end
        cmp_near(c, exp_c, 5);
        cmp8({7'h0, no_resp_flag_ff}, {7'h0, exp_f});
    endtask
    // read data watcher takes the oldest note per answer
    always @(posedge clk_sys) begin
        if (host_rvalid_ff === 1'b1) begin
            cmp8(host_rdata_ff, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 44;
        err_total = 0;
        total_checks = 0;
        rst = 1'b1;
        tx_pulse_req = 1'b0;
        tx_eof_done = 1'b0;
        anticoll_slot = 1'b0;
        tag_resp_start = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmp8(dec_out, dec(8'h02));
        rd(5'h01, 8'h02);
        rd(5'h06, 8'h00);
        rd(5'h07, 8'h0e);
        for (i = 0; i < 8; i++) begin
            v = (8'($random(seed)) & 8'hc0) | 8'(i);
            wr(5'h06, 8'h33);
            wr(5'h07, 8'h5c);
            wr(5'h01, v);
            cmp8(dec_out, dec(v));
            rd(5'h01, v);
            rd(5'h06, 8'h00);
            rd(5'h07, v[1] ? 8'h14 : 8'h30);
        end
        wr(5'h03, 8'ha5);
        rd(5'h03, 8'h00);
        u_host_model.set_en(1'b0);
        repeat (6) @(posedge clk_sys);
        wr(5'h07, 8'h99);
        u_host_model.set_en(1'b1);
        repeat (4) @(posedge clk_sys);
        cmp8(dec_out, dec(8'h02));
        rd(5'h06, 8'h00);
        rd(5'h07, 8'h0e);
        plen[1] = 8'($random(seed)) | 8'h01;
        for (i = 0; i < 4; i++) begin
            wr(5'h06, plen[i]);
            pulse(plen[i] == 8'h00 ? 378 : (plen[i] * 4000 + 678) / 1356);
        end
        wr(5'h07, 8'h02);
        anticoll_slot <= 1'b1;
        slot(1'b1, 5000, 1'b0);
        anticoll_slot <= 1'b0;
        slot(1'b0, 5000, 1'b0);
        anticoll_slot <= 1'b1;
        slot(1'b0, 3021, 1'b1);
        slot(1'b1, 5000, 1'b0);
        finish_test();
    end
endmodule // tb_rfid_protocol_config
